// file: src/ir_ambient_pkg.sv
`default_nettype none
package ir_ambient_pkg;
  // Register indices (printed offsets are not multiples of four)
  localparam logic [7:0] IDX_INTEG_SCALE = 8'h1E;
  localparam logic [7:0] IDX_MISC = 8'h1F;
  localparam logic [7:0] IDX_CTRL = 8'h20;
  localparam logic [7:0] IDX_STATUS = 8'h21;
  // Byte addresses are four times the index
  localparam logic [11:0] ADDR_INTEG_SCALE = {2'h0, IDX_INTEG_SCALE, 2'h0};
  localparam logic [11:0] ADDR_MISC = {2'h0, IDX_MISC, 2'h0};
  localparam logic [11:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [11:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
  // Field layout
  localparam int SCALE_W = 3;
  localparam int RANGE_BIT = 5;
  localparam int MISC_RSVD_W = 5;
  localparam logic [7:0] SCALE_RESET = 8'h00;
  localparam logic [7:0] MISC_RESET = 8'h00;
  localparam logic [SCALE_W-1:0] SCALE_MAX = 3'h7;
  // Sequencer revision that first honours the scale (A03)
  localparam logic [7:0] SEQ_REV_SCALE_MIN = 8'h03;
  localparam int DIV_W = 8;
  // Divider: 2 ** scale, up to 128
  localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
  typedef struct packed {
    logic [SCALE_W-1:0] scale;
    logic highRange;
  } adc_cfg_t;
  typedef enum logic [1:0] {
    IDLE_S = 2'b00,
    ACCESS_S = 2'b01
  } apb_state_t;
endpackage
`default_nettype wire

// file: src/ir_ambient_adc_config.sv
`default_nettype none
module ir_ambient_adc_config
  import ir_ambient_pkg::*;
(
  input wire logic clock, // 20 MHz system clock
  input wire logic reset, // Synchronous, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic [7:0] seqRevision, // Sequencer revision number
  input wire logic eventIn, // Programmed event request
  input wire logic intIn, // Interrupt wire level
  output logic intOut, // Interrupt pin output value
  output logic intOe, // Interrupt pin enable, high drives low
  output logic adcClkEn, // One pulse per divided ADC clock
  output ir_ambient_pkg::adc_cfg_t adcCfg // Active converter setup
);
  import ir_ambient_pkg::*;

  // Integer power of two, used by the divider
  // Eight bits hold the largest factor, so the shift never overflows
  // for any legal code; a wider code would need a wider result
  // Kept as a function; the divider compare is its only caller
  function automatic logic [DIV_W-1:0] div_of(input logic [SCALE_W-1:0] s);
    div_of = DIV_ONE << s;
  endfunction

  logic [7:0] scale_r, scale_nxt; // Scale parameter storage
  logic [7:0] misc_r, misc_nxt; // Misc parameter storage
  logic eventEn_r, eventEn_nxt; // Software enable for events
  logic eventPend_r, eventPend_nxt; // Sticky event, drives the pin
  logic [31:0] prdata_r, prdata_nxt; // Registered read data
  logic pready_r, pready_nxt; // Registered ready
  logic pslverr_r, pslverr_nxt; // Registered error
  apb_state_t st_r, st_nxt; // Bus state
  logic [DIV_W-1:0] divCnt_r, divCnt_nxt; // Clock divider count
  logic adcClkEn_r, adcClkEn_nxt; // Divided clock pulse
  adc_cfg_t cfg_r, cfg_nxt; // Configuration seen by converter
  logic [SCALE_W-1:0] effScale; // Scale after revision gate
  logic mapped; // Address decodes to a register
  logic wrAcc; // Write accepted this cycle
  logic clrEvent; // Software clears event

  // Address decode
  // Only the four word addresses are mapped; everything else is
  // answered with an error and leaves the registers untouched
  // Sub-word addresses are not mapped either
  always_comb
  begin
    mapped = (paddr == ADDR_INTEG_SCALE) || (paddr == ADDR_MISC) ||
             (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS);
  end

  // Older sequencers ignore the scale and run undivided
  // The stored value is kept, so a later revision change takes it up
  // at once; software needs no rewrite after the revision switches
  // The revision input is treated as a level, not an event
  always_comb
  begin
    if (seqRevision >= SEQ_REV_SCALE_MIN)
      effScale = scale_r[SCALE_W-1:0];
    else
      effScale = '0;
  end

  // APB slave: one wait state, answer in the second access cycle after setup
  // Ready is registered to keep the bus outputs free of decode paths;
  // the cost is one extra cycle on every transfer
  // A write lands only at the edge where ready is seen high
  // Read data is cleared on errors so no stale value leaks out
  always_comb
  begin
    st_nxt = st_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    wrAcc = 1'b0;
    unique case (st_r)
      IDLE_S:
      begin
        if (psel && !penable)
          st_nxt = ACCESS_S;
      end
      ACCESS_S:
      begin
        if (psel && penable && !pready_r)
        begin
          pready_nxt = 1'b1;
          pslverr_nxt = !mapped;
          prdata_nxt = '0;
          if (!pwrite && mapped)
          begin
            if (paddr == ADDR_INTEG_SCALE)
              prdata_nxt = {24'h00_0000, scale_r};
            else if (paddr == ADDR_MISC)
              prdata_nxt = {24'h00_0000, misc_r};
            else if (paddr == ADDR_CTRL)
              prdata_nxt = {31'h0000_0000, eventEn_r};
            else
              prdata_nxt = {30'h0000_0000, intIn, eventPend_r};
          end
        end
        else if (pready_r)
          st_nxt = IDLE_S;
      end
    endcase
    if (psel && penable && pready_r && pwrite && mapped)
      wrAcc = 1'b1;
  end

  // Register writes; reserved scale bits kept as zero
  // Misc keeps all eight bits; preserving the reserved ones is left
  // to the host, which must read before it writes
  // The status write only clears, it can never raise the event
  always_comb
  begin
    scale_nxt = scale_r;
    misc_nxt = misc_r;
    eventEn_nxt = eventEn_r;
    clrEvent = 1'b0;
    if (wrAcc)
    begin
      if (paddr == ADDR_INTEG_SCALE)
        scale_nxt = {5'h00, pwdata[SCALE_W-1:0]};
      else if (paddr == ADDR_MISC)
        misc_nxt = pwdata[7:0];
      else if (paddr == ADDR_CTRL)
        eventEn_nxt = pwdata[0];
      else
        clrEvent = pwdata[0];
    end
    // Event set wins over a simultaneous clear
    eventPend_nxt = eventPend_r;
    if (clrEvent)
      eventPend_nxt = 1'b0;
    if (eventIn && eventEn_r)
      eventPend_nxt = 1'b1;
  end

  // Divider: one enable pulse each 2 ** scale clocks
  // The compare uses greater-or-equal so a drop to a smaller scale
  // wraps at once instead of running through the old long count
  // New settings reach the converter one clock after the register
  always_comb
  begin
    cfg_nxt.scale = effScale;
    cfg_nxt.highRange = misc_r[RANGE_BIT];
    adcClkEn_nxt = 1'b0;
    if (divCnt_r >= div_of(cfg_r.scale) - DIV_ONE)
    begin
      divCnt_nxt = '0;
      adcClkEn_nxt = 1'b1;
    end
    else
      divCnt_nxt = divCnt_r + DIV_ONE;
  end

  // State registers
  // Reset is synchronous; all state returns to known constants
  // The divider restarts so the first pulse follows release at once
  // Nothing here depends on the bus during reset
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      scale_r <= SCALE_RESET;
      misc_r <= MISC_RESET;
      eventEn_r <= 1'b0;
      eventPend_r <= 1'b0;
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      st_r <= IDLE_S;
      divCnt_r <= '0;
      adcClkEn_r <= 1'b0;
      cfg_r <= '0;
    end
    else
    begin
      scale_r <= scale_nxt;
      misc_r <= misc_nxt;
      eventEn_r <= eventEn_nxt;
      eventPend_r <= eventPend_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      st_r <= st_nxt;
      divCnt_r <= divCnt_nxt;
      adcClkEn_r <= adcClkEn_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  // Outputs straight from flip-flops; pin never driven high
  // The pin value is tied low: only the enable moves, so the wire
  // can only be released to its pull-up or sunk by the device
  // Sharing the line with other open-drain parts is therefore safe
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign intOut = 1'b0;
  assign intOe = eventPend_r;
  assign adcClkEn = adcClkEn_r;
  assign adcCfg = cfg_r;

  // Checks
  // All checks run on the single clock and are held off during reset
  // except the two that look at the first cycle after it

  // The pin value itself must never be high
  a_int_never_high: assert property (@(posedge clock) disable iff (reset)
    intOut == 1'b0)
    else $error("interrupt pin driven high");

  // Scale comes out of reset as zero
  a_scale_reset: assert property (@(posedge clock)
    $past(reset) |-> scale_r == SCALE_RESET)
    else $error("scale not zero after reset");

  // The pin is released right after reset
  a_pin_reset_release: assert property (@(posedge clock)
    $past(reset) |-> !intOe)
    else $error("interrupt pin sunk after reset");

  // Stored scale never exceeds the top code
  a_scale_max: assert property (@(posedge clock) disable iff (reset)
    scale_r[7:SCALE_W] == '0 && scale_r[SCALE_W-1:0] <= SCALE_MAX)
    else $error("scale above seven");

  // Range bit reaches the converter one clock later
  a_range_follow: assert property (@(posedge clock) disable iff (reset)
    ##1 cfg_r.highRange == $past(misc_r[RANGE_BIT]))
    else $error("range bit not applied");

  // Older sequencer always sees an undivided clock
  a_old_seq_gate: assert property (@(posedge clock) disable iff (reset)
    seqRevision < SEQ_REV_SCALE_MIN |=> cfg_r.scale == '0)
    else $error("old sequencer used scale");

  // Newer sequencer sees the stored scale one clock later
  a_scale_follow: assert property (@(posedge clock) disable iff (reset)
    seqRevision >= SEQ_REV_SCALE_MIN |=>
    cfg_r.scale == $past(scale_r[SCALE_W-1:0]))
    else $error("scale not applied");

  // Undivided clock pulses on every cycle
  a_div_period: assert property (@(posedge clock) disable iff (reset)
    adcClkEn_r && cfg_r.scale == '0 && $stable(cfg_r.scale) |=>
    adcClkEn_r || cfg_r.scale != '0)
    else $error("undivided clock missed pulse");

  // A pulse always coincides with a restarted count
  a_div_gap: assert property (@(posedge clock) disable iff (reset)
    adcClkEn_r |-> divCnt_r == '0)
    else $error("divider pulse off the wrap point");

  // A misc write stores the written byte
  a_misc_keep: assert property (@(posedge clock) disable iff (reset)
    wrAcc && paddr == ADDR_MISC |=> misc_r == $past(pwdata[7:0]))
    else $error("misc write lost");

  // A write to an unmapped address changes no parameter
  a_unmapped_ignored: assert property (@(posedge clock)
    disable iff (reset)
    psel && penable && pready_r && pwrite && !mapped |=>
    $stable(scale_r) && $stable(misc_r))
    else $error("unmapped write changed a register");

  // An event wins over a clear in the same cycle
  a_event_set_wins: assert property (@(posedge clock) disable iff (reset)
    eventIn && eventEn_r |=> eventPend_r)
    else $error("event lost");

  // Ready stands for exactly one cycle
  a_ready_one_cycle: assert property (@(posedge clock)
    disable iff (reset)
    pready_r |=> !pready_r)
    else $error("ready held too long");

  // Error only comes with ready, and carries no read data
  a_err_with_ready: assert property (@(posedge clock) disable iff (reset)
    pslverr_r |-> pready_r && prdata_r == '0)
    else $error("error without ready");

  // Main scenarios
  c_scale_write: cover property (@(posedge clock) wrAcc &&
    paddr == ADDR_INTEG_SCALE);
  c_high_range: cover property (@(posedge clock) cfg_r.highRange);
  c_int_assert: cover property (@(posedge clock) $rose(intOe));
  c_old_seq: cover property (@(posedge clock)
    seqRevision < SEQ_REV_SCALE_MIN && scale_r != '0);
endmodule
`default_nettype wire

// file: tb/int_line_model.sv
`default_nettype none
module int_line_model (
  input wire logic intOut, // Device pin value
  input wire logic intOe, // Device sink enable
  output logic intWire // Resolved wire level
);
  timeunit 1ns;
  timeprecision 1ns;
  // Host pull-up keeps the line high once reset has cleared the enable, unless
  // the device sinks it; a driven high reads through as is
  always_comb
  begin
    intWire = intOe ? intOut : 1'b1;
  end
endmodule
`default_nettype wire

// file: tb/ir_ambient_adc_config_tb_top.sv
`default_nettype none
module ir_ambient_adc_config_tb_top;
  import ir_ambient_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000; // Byte address
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, intOut, intOe, adcClkEn, intWire;
  logic eventIn = 0; // Event request
  logic [7:0] seqRevision = 8'h03; // Revision that honours scale
  adc_cfg_t adcCfg;
  int mismatches = 0, checks = 0, cyc = 0, p;
  logic [7:0] codes [4] = '{8'h00, 8'h04, 8'h06, 8'h07};
  ir_ambient_adc_config ir_ambient_adc_config_i (.clock(clock),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .seqRevision(seqRevision), .eventIn(eventIn),
    .intIn(intWire), .intOut(intOut), .intOe(intOe),
    .adcClkEn(adcClkEn), .adcCfg(adcCfg));
  int_line_model int_line_model_i (.intOut(intOut), .intOe(intOe),
    .intWire(intWire));
  always #25 clock = ~clock;
  // Watchdog: whole run is under a thousand cycles
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  // Edges between two divided-clock pulses
  task automatic gap(output int n);
    n = 0;
    do @(posedge clock); while (adcClkEn !== 1'b1);
    do
    begin
      @(posedge clock);
      n++;
    end
    while (adcClkEn !== 1'b1);
  endtask
  initial
  begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    chk(32'(intWire), 32'h0000_0001);
    apb(1'b0, ADDR_INTEG_SCALE, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(32'(adcCfg), 32'h0000_0000);
    gap(p);
    chk(32'(p), 32'h0000_0001);
    $display("test reset done");
    // Reserved upper bits written high must read back clear
    foreach (codes[i])
    begin
      apb(1'b1, ADDR_INTEG_SCALE, {24'h00_0000, 5'h1F, codes[i][2:0]});
      apb(1'b0, ADDR_INTEG_SCALE, 32'h0000_0000);
      chk(rd, {24'h00_0000, codes[i]});
      chk(32'(adcCfg.scale), 32'(codes[i]));
      gap(p);
      gap(p);
      chk(32'(p), 32'h0000_0001 << codes[i]);
    end
    $display("test scale done");
    // An older sequencer must run undivided whatever is stored
    seqRevision <= 8'h02;
    repeat (2) @(posedge clock);
    chk(32'(adcCfg.scale), 32'h0000_0000);
    gap(p);
    gap(p);
    chk(32'(p), 32'h0000_0001);
    seqRevision <= 8'h03;
    $display("test old sequencer done");
    // Host side: read-modify-write keeps the low five bits
    apb(1'b1, ADDR_MISC, 32'h0000_0015);
    apb(1'b0, ADDR_MISC, 32'h0000_0000);
    apb(1'b1, ADDR_MISC, rd | 32'h0000_0020);
    apb(1'b0, ADDR_MISC, 32'h0000_0000);
    chk(rd, 32'h0000_0035);
    chk(32'(adcCfg.highRange), 32'h0000_0001);
    apb(1'b1, ADDR_MISC, rd & 32'hFFFF_FFDF);
    @(posedge clock);
    chk(32'(adcCfg.highRange), 32'h0000_0000);
    $display("test range done");
    apb(1'b1, 12'hFFC, 32'h0000_0001);
    chk(32'(err), 32'h0000_0001);
    apb(1'b0, 12'hFFC, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("test unmapped done");
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    eventIn <= 1'b1;
    @(posedge clock);
    eventIn <= 1'b0;
    repeat (3) @(posedge clock);
    chk({30'h0, intOe, intOut}, 32'h0000_0002);
    chk(32'(intWire), 32'h0000_0000);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    apb(1'b1, ADDR_STATUS, 32'h0000_0001);
    repeat (2) @(posedge clock);
    chk(32'(intWire), 32'h0000_0001);
    $display("test interrupt done");
    end_sim();
  end
endmodule
`default_nettype wire
